// ===== vpit_top.sv
// Purpose: Vectored interrupt prioritisation and fetch address generation
// Assumes: Sources are level requests synchronous to sys_clk_i
// Notes:   Table entries are filled by software, not by this block
`timescale 1ns/1ps
`include "vpit_map.svh"

module vpit_top #(
  parameter int NUM_VEC = `VPIT_NUM_VEC
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // Core exceptions
  input  wire logic                      illegal_instr_i,
  input  wire logic                      swi3_i,
  input  wire logic                      stack_overflow_i,
  input  wire logic                      misaligned_i,
  // Software interrupts 2..0
  input  wire logic                      swi2_i,
  input  wire logic                      swi1_i,
  input  wire logic                      swi0_i,
  // Debug port
  input  wire logic                      debug_port_step_i,
  input  wire logic                      debug_port_brk0_i,
  input  wire logic                      debug_port_trace_i,
  input  wire logic                      debug_port_tx_empty_i,
  input  wire logic                      debug_port_rx_full_i,
  // External, supply and clock
  input  wire logic                      external_irq_pin_a_i,
  input  wire logic                      external_irq_pin_b_i,
  input  wire logic                      low_voltage_detect_i,
  input  wire logic                      clock_synth_i,
  // Flash controller
  input  wire logic                      flash_controller_err_i,
  input  wire logic                      flash_controller_done_i,
  input  wire logic                      flash_controller_empty_i,
  // CAN: bus-off, error, wake-up, message buffer
  input  wire logic [3:0]                can_irq_i,
  // GPIO ports, bit 0 is port A
  input  wire logic [5:0]                gpio_port_event_i,
  // Sync serial: bit 0 receiver full, bit 1 transmitter empty
  input  wire logic [1:0]                sync_serial_1_i,
  input  wire logic [1:0]                sync_serial_0_i,
  // Async serial 1
  input  wire logic                      async_serial_1_tx_empty_i,
  input  wire logic                      async_serial_1_tx_idle_i,
  input  wire logic                      async_serial_1_rx_error_i,
  input  wire logic                      async_serial_1_rx_full_i,
  // Quadrature decoders
  input  wire logic                      quad_decoder_1_home_i,
  input  wire logic                      quad_decoder_1_index_i,
  input  wire logic                      quad_decoder_0_home_i,
  // Software configuration
  input  wire logic [`VPIT_BASE_W-1:0]   vector_table_base_i,
  input  wire logic [NUM_VEC*2-1:0]      level_cfg_i,
  // Core side
  input  wire logic                      irq_ack_i,
  output logic                           irq_req_o,
  output vpit_pkg::vpit_vector_t         irq_vector_o,
  output vpit_pkg::vpit_level_t          irq_level_o,
  output logic [`VPIT_ADDR_W-1:0]        irq_fetch_addr_o
);
  import vpit_pkg::*;

  logic [NUM_VEC-1:0]          raw_pend;
  logic [NUM_VEC-1:0]          pend;
  logic [NUM_VEC-1:0]          valid_vec;
  logic [NUM_VEC*2-1:0]        eff_level;
  logic [`VPIT_BASE_W-1:0]     base_q;
  logic                        hit;
  vpit_vector_t                win_vec;
  vpit_level_t                 win_lvl;
  logic [`VPIT_ADDR_W-1:0]     addr_d;

  // ****************************************
  // Fetch address of a vector
  // ****************************************
  function automatic logic [`VPIT_ADDR_W-1:0] vpit_addr(
    input logic [`VPIT_BASE_W-1:0] base,
    input vpit_vector_t            vec
  );
    logic [`VPIT_ADDR_W-1:0] b;
    logic [`VPIT_ADDR_W-1:0] off;
    b   = {{(`VPIT_ADDR_W-`VPIT_BASE_W){1'b0}}, base};
    off = {{(`VPIT_ADDR_W-`VPIT_VEC_W){1'b0}}, vec};
    vpit_addr = `VPIT_ADDR_W'((b << `VPIT_BASE_SHIFT) + off * `VPIT_ENTRY_WORDS);
  endfunction

  // ****************************************
  // Source to vector slot mapping
  // ****************************************
  always_comb begin
    raw_pend = '0;
    raw_pend[`VPIT_VEC_ILLEGAL]   = illegal_instr_i;
    raw_pend[`VPIT_VEC_SWI3]      = swi3_i;
    raw_pend[`VPIT_VEC_STACK_OVF] = stack_overflow_i;
    raw_pend[`VPIT_VEC_MISALIGN]  = misaligned_i;
    raw_pend[`VPIT_VEC_DBG_STEP]  = debug_port_step_i;
    raw_pend[`VPIT_VEC_DBG_BRK0]  = debug_port_brk0_i;
    raw_pend[`VPIT_VEC_DBG_TRACE] = debug_port_trace_i;
    raw_pend[`VPIT_VEC_DBG_TXE]   = debug_port_tx_empty_i;
    raw_pend[`VPIT_VEC_DBG_RXF]   = debug_port_rx_full_i;
    raw_pend[`VPIT_VEC_SWI2]      = swi2_i;
    raw_pend[`VPIT_VEC_SWI1]      = swi1_i;
    raw_pend[`VPIT_VEC_SWI0]      = swi0_i;
    raw_pend[`VPIT_VEC_IRQ_A]     = external_irq_pin_a_i;
    raw_pend[`VPIT_VEC_IRQ_B]     = external_irq_pin_b_i;
    raw_pend[`VPIT_VEC_LVD]       = low_voltage_detect_i;
    raw_pend[`VPIT_VEC_CLK_SYN]   = clock_synth_i;
    raw_pend[`VPIT_VEC_FL_ERR]    = flash_controller_err_i;
    raw_pend[`VPIT_VEC_FL_DONE]   = flash_controller_done_i;
    raw_pend[`VPIT_VEC_FL_EMPTY]  = flash_controller_empty_i;
    raw_pend[`VPIT_VEC_CAN_HI:`VPIT_VEC_CAN_LO] = can_irq_i;
    for (int p = 0; p < 6; p++) begin
      raw_pend[`VPIT_VEC_GPIO_HI - p] = gpio_port_event_i[p];
    end
    raw_pend[`VPIT_VEC_SS1_HI:`VPIT_VEC_SS1_LO] = sync_serial_1_i;
    raw_pend[`VPIT_VEC_SS0_HI:`VPIT_VEC_SS0_LO] = sync_serial_0_i;
    raw_pend[`VPIT_VEC_AS1_TXE]   = async_serial_1_tx_empty_i;
    raw_pend[`VPIT_VEC_AS1_TXI]   = async_serial_1_tx_idle_i;
    raw_pend[`VPIT_VEC_AS1_RXE]   = async_serial_1_rx_error_i;
    raw_pend[`VPIT_VEC_AS1_RXF]   = async_serial_1_rx_full_i;
    raw_pend[`VPIT_VEC_QD1_HOME]  = quad_decoder_1_home_i;
    raw_pend[`VPIT_VEC_QD1_INDEX] = quad_decoder_1_index_i;
    raw_pend[`VPIT_VEC_QD0_HOME]  = quad_decoder_0_home_i;
  end

  // ****************************************
  // Level assignment and validity
  // ****************************************
  // Per-source levels: fixed for core exceptions and software interrupts, assignable for the rest
  vpit_level_map #(
    .NUM_VEC     (NUM_VEC)
  ) u_level_map (
    .req_level_i (level_cfg_i),
    .eff_level_o (eff_level),
    .valid_vec_o (valid_vec)
  );

  assign pend = raw_pend & valid_vec;

  // ****************************************
  // Priority selection
  // ****************************************
  vpit_arbiter #(
    .NUM_VEC (NUM_VEC)
  ) u_arbiter (
    .pend_i  (pend),
    .level_i (eff_level),
    .hit_o   (hit),
    .vec_o   (win_vec),
    .lvl_o   (win_lvl)
  );

  // ****************************************
  // Table base register
  // ****************************************
  // Software-written base
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      base_q <= `VPIT_BASE_RST;
    end else begin
      base_q <= vector_table_base_i;
    end
  end

  assign addr_d = vpit_addr(base_q, win_vec);

  // ****************************************
  // Core request outputs
  // ****************************************
  // Vector, address with request
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_req_o        <= 1'b0;
      irq_vector_o     <= '0;
      irq_level_o      <= `VPIT_LVL_RST;
      irq_fetch_addr_o <= '0;
    end else if (irq_ack_i && irq_req_o) begin
      irq_req_o        <= 1'b0;
      irq_vector_o     <= '0;
      irq_level_o      <= `VPIT_LVL_RST;
      irq_fetch_addr_o <= '0;
    end else begin
      irq_req_o        <= hit;
      irq_vector_o     <= hit ? win_vec : '0;
      irq_level_o      <= hit ? win_lvl : `VPIT_LVL_RST;
      irq_fetch_addr_o <= hit ? addr_d : '0;
    end
  end

endmodule

// ===== vpit_map.svh
// Purpose: Constants for the vectored priority interrupt table
// Assumes: Included by bare name
// Notes:   Vector numbers, fixed levels, table geometry
`ifndef VPIT_MAP_SVH
`define VPIT_MAP_SVH

`define VPIT_NUM_VEC        50
`define VPIT_VEC_W          6
`define VPIT_LVL_W          2
`define VPIT_ADDR_W         21
`define VPIT_BASE_W         16
`define VPIT_BASE_SHIFT     8
`define VPIT_ENTRY_WORDS    2
`define VPIT_REACH_BITS     19
`define VPIT_BASE_RST       16'h0000
`define VPIT_LVL_RST        2'h0

// Fixed core exceptions
`define VPIT_VEC_ILLEGAL    6'h02
`define VPIT_VEC_SWI3       6'h03
`define VPIT_VEC_STACK_OVF  6'h04
`define VPIT_VEC_MISALIGN   6'h05
// Debug port
`define VPIT_VEC_DBG_STEP   6'h06
`define VPIT_VEC_DBG_BRK0   6'h07
`define VPIT_VEC_DBG_TRACE  6'h09
`define VPIT_VEC_DBG_TXE    6'h0a
`define VPIT_VEC_DBG_RXF    6'h0b
// Software interrupts 2..0
`define VPIT_VEC_SWI2       6'h0e
`define VPIT_VEC_SWI1       6'h0f
`define VPIT_VEC_SWI0       6'h10
// External, supply, clock
`define VPIT_VEC_IRQ_A      6'h11
`define VPIT_VEC_IRQ_B      6'h12
`define VPIT_VEC_LVD        6'h14
`define VPIT_VEC_CLK_SYN    6'h15
// Flash controller
`define VPIT_VEC_FL_ERR     6'h16
`define VPIT_VEC_FL_DONE    6'h17
`define VPIT_VEC_FL_EMPTY   6'h18
// CAN and GPIO ranges
`define VPIT_VEC_CAN_LO     6'h1a
`define VPIT_VEC_CAN_HI     6'h1d
`define VPIT_VEC_GPIO_LO    6'h1e
`define VPIT_VEC_GPIO_HI    6'h23
// Synchronous serial
`define VPIT_VEC_SS1_LO     6'h26
`define VPIT_VEC_SS1_HI     6'h27
`define VPIT_VEC_SS0_LO     6'h28
`define VPIT_VEC_SS0_HI     6'h29
// Async serial 1
`define VPIT_VEC_AS1_TXE    6'h2a
`define VPIT_VEC_AS1_TXI    6'h2b
`define VPIT_VEC_AS1_RXE    6'h2d
`define VPIT_VEC_AS1_RXF    6'h2e
// Quadrature decoders
`define VPIT_VEC_QD1_HOME   6'h2f
`define VPIT_VEC_QD1_INDEX  6'h30
`define VPIT_VEC_QD0_HOME   6'h31

// Fixed levels
`define VPIT_LVL_3          2'h3
`define VPIT_LVL_2          2'h2
`define VPIT_LVL_1          2'h1
`define VPIT_LVL_0          2'h0

`endif

// ===== vpit_pkg.sv
// Purpose: Types for the vectored priority interrupt table
// Assumes: vpit_map.svh constants
// Notes:   Level range classes per vector
package vpit_pkg;

  // Allowed level range of a vector
  typedef enum logic [2:0] {
    VPIT_RANGE_NONE,
    VPIT_RANGE_FIX3,
    VPIT_RANGE_FIX2,
    VPIT_RANGE_FIX1,
    VPIT_RANGE_FIX0,
    VPIT_RANGE_1_3,
    VPIT_RANGE_0_2
  } vpit_range_t;

  typedef logic [1:0] vpit_level_t;
  typedef logic [5:0] vpit_vector_t;

endpackage

// ===== vpit_level_map.sv
// Purpose: Per-vector effective level and validity
// Assumes: Level requests come from the software-side level fields
// Notes:   Out-of-range requests are clamped into the allowed range
`timescale 1ns/1ps
`include "vpit_map.svh"

module vpit_level_map #(
  parameter int NUM_VEC = `VPIT_NUM_VEC
) (
  // Requested levels
  input  wire logic [NUM_VEC*2-1:0] req_level_i,
  // Effective levels and validity
  output logic      [NUM_VEC*2-1:0] eff_level_o,
  output logic      [NUM_VEC-1:0]   valid_vec_o
);
  import vpit_pkg::*;

  // ****************************************
  // Range class of each vector
  // ****************************************
  function automatic vpit_range_t vpit_range(input int unsigned v);
    vpit_vector_t n;
    n = v[5:0];
    if (n < `VPIT_VEC_ILLEGAL) begin
      vpit_range = VPIT_RANGE_NONE;
    end else if (n <= `VPIT_VEC_MISALIGN) begin
      vpit_range = VPIT_RANGE_FIX3;
    end else if (n == `VPIT_VEC_DBG_STEP || n == `VPIT_VEC_DBG_BRK0 ||
                 n == `VPIT_VEC_DBG_TRACE || n == `VPIT_VEC_DBG_TXE ||
                 n == `VPIT_VEC_DBG_RXF) begin
      vpit_range = VPIT_RANGE_1_3;
    end else if (n == `VPIT_VEC_SWI2) begin
      vpit_range = VPIT_RANGE_FIX2;
    end else if (n == `VPIT_VEC_SWI1) begin
      vpit_range = VPIT_RANGE_FIX1;
    end else if (n == `VPIT_VEC_SWI0) begin
      vpit_range = VPIT_RANGE_FIX0;
    end else if (n == `VPIT_VEC_IRQ_A || n == `VPIT_VEC_IRQ_B ||
                 n == `VPIT_VEC_LVD || n == `VPIT_VEC_CLK_SYN ||
                 (n >= `VPIT_VEC_FL_ERR && n <= `VPIT_VEC_FL_EMPTY) ||
                 (n >= `VPIT_VEC_CAN_LO && n <= `VPIT_VEC_GPIO_HI) ||
                 (n >= `VPIT_VEC_SS1_LO && n <= `VPIT_VEC_AS1_TXI) ||
                 (n >= `VPIT_VEC_AS1_RXE && n <= `VPIT_VEC_QD0_HOME)) begin
      vpit_range = VPIT_RANGE_0_2;
    end else begin
      vpit_range = VPIT_RANGE_NONE;
    end
  endfunction

  // ****************************************
  // Clamp each level into its range
  // ****************************************
  always_comb begin
    vpit_level_t rq;
    rq = `VPIT_LVL_0;
    for (int v = 0; v < NUM_VEC; v++) begin
      rq = req_level_i[v*2 +: 2];
      valid_vec_o[v] = 1'b1;
      case (vpit_range(v))
        VPIT_RANGE_FIX3: eff_level_o[v*2 +: 2] = `VPIT_LVL_3;
        VPIT_RANGE_FIX2: eff_level_o[v*2 +: 2] = `VPIT_LVL_2;
        VPIT_RANGE_FIX1: eff_level_o[v*2 +: 2] = `VPIT_LVL_1;
        VPIT_RANGE_FIX0: eff_level_o[v*2 +: 2] = `VPIT_LVL_0;
        VPIT_RANGE_1_3: eff_level_o[v*2 +: 2] = (rq == `VPIT_LVL_0) ? `VPIT_LVL_1 : rq;
        VPIT_RANGE_0_2: eff_level_o[v*2 +: 2] = (rq == `VPIT_LVL_3) ? `VPIT_LVL_2 : rq;
        default: begin
          eff_level_o[v*2 +: 2] = `VPIT_LVL_0;
          valid_vec_o[v] = 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== vpit_arbiter.sv
// Purpose: Level-then-vector priority selection
// Assumes: Pending bits already masked by validity
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "vpit_map.svh"

module vpit_arbiter #(
  parameter int NUM_VEC = `VPIT_NUM_VEC
) (
  // Requests
  input  wire logic [NUM_VEC-1:0]   pend_i,
  input  wire logic [NUM_VEC*2-1:0] level_i,
  // Winner
  output logic                      hit_o,
  output vpit_pkg::vpit_vector_t    vec_o,
  output vpit_pkg::vpit_level_t     lvl_o
);
  import vpit_pkg::*;

  // ****************************************
  // Scan levels high to low
  // ****************************************
  always_comb begin
    hit_o = 1'b0;
    vec_o = '0;
    lvl_o = `VPIT_LVL_0;
    for (int l = 3; l >= 0; l--) begin
      for (int v = NUM_VEC - 1; v >= 0; v--) begin
        if (!hit_o && pend_i[v] && level_i[v*2 +: 2] == l[1:0]) begin
          vec_o = v[5:0];
          lvl_o = l[1:0];
        end
      end
      if (!hit_o) begin
        for (int v = 0; v < NUM_VEC; v++) begin
          if (pend_i[v] && level_i[v*2 +: 2] == l[1:0]) begin
            hit_o = 1'b1;
          end
        end
      end
    end
  end

endmodule

// ===== vpit_top_asserts.sv
// Purpose: Port properties of the interrupt table
// Assumes: Bound to vpit_top
// Notes:   One clock domain
`timescale 1ns/1ps
`include "vpit_map.svh"

module vpit_top_asserts
  import vpit_pkg::*;
#(
  parameter int NUM_VEC = `VPIT_NUM_VEC
) (
  input wire logic sys_clk_i, srst_i,
  input wire logic illegal_instr_i, swi3_i, stack_overflow_i, misaligned_i,
  input wire logic swi2_i, swi1_i, swi0_i,
  input wire logic debug_port_step_i, debug_port_brk0_i, debug_port_trace_i,
  input wire logic debug_port_tx_empty_i, debug_port_rx_full_i,
  input wire logic external_irq_pin_a_i, external_irq_pin_b_i,
  input wire logic low_voltage_detect_i, clock_synth_i,
  input wire logic flash_controller_err_i, flash_controller_done_i, flash_controller_empty_i,
  input wire logic [3:0] can_irq_i,
  input wire logic [5:0] gpio_port_event_i,
  input wire logic [1:0] sync_serial_1_i, sync_serial_0_i,
  input wire logic async_serial_1_tx_empty_i, async_serial_1_tx_idle_i,
  input wire logic async_serial_1_rx_error_i, async_serial_1_rx_full_i,
  input wire logic quad_decoder_1_home_i, quad_decoder_1_index_i, quad_decoder_0_home_i,
  input wire logic [`VPIT_BASE_W-1:0] vector_table_base_i,
  input wire logic [NUM_VEC*2-1:0] level_cfg_i,
  input wire logic irq_ack_i, irq_req_o,
  input wire vpit_vector_t irq_vector_o,
  input wire vpit_level_t irq_level_o,
  input wire logic [`VPIT_ADDR_W-1:0] irq_fetch_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  chk_addr_base: assert property (irq_req_o && !$past(srst_i) && !$past(srst_i, 2)
    |-> irq_fetch_addr_o == 21'({$past(vector_table_base_i, 2), 8'h00}) + 21'(2 * irq_vector_o))
    else $error("fetch address mismatch");
  chk_no_reserved: assert property (irq_req_o
    |-> !(irq_vector_o inside {0, 1, 8, 12, 13, 19, 25, 36, 37, 44}) && irq_vector_o < 6'd50)
    else $error("reserved vector issued");
  chk_core_fixed: assert property (irq_req_o && irq_vector_o inside {[2:5]}
    |-> irq_level_o == 2'h3) else $error("core exception level wrong");
  chk_swi_fixed: assert property (irq_req_o && irq_vector_o inside {[14:16]}
    |-> irq_level_o == 2'(6'h10 - irq_vector_o)) else $error("software level wrong");
  chk_dbg_range: assert property (irq_req_o && irq_vector_o inside {[6:11]}
    |-> irq_level_o != 2'h0) else $error("debug level out of range");
  chk_periph_range: assert property (irq_req_o && irq_vector_o >= 6'd17
    |-> irq_level_o != 2'h3) else $error("peripheral level out of range");
  chk_ack_clear: assert property (irq_ack_i && irq_req_o
    |=> !irq_req_o && irq_fetch_addr_o == '0) else $error("ack did not clear request");
  chk_level3_first: assert property ((illegal_instr_i || swi3_i || stack_overflow_i
    || misaligned_i) && !(irq_ack_i && irq_req_o)
    |=> irq_req_o && irq_level_o == 2'h3 && irq_vector_o <= 6'd5)
    else $error("level 3 exception not taken first");
  chk_idle_zero: assert property (!irq_req_o
    |-> irq_vector_o == '0 && irq_level_o == '0 && irq_fetch_addr_o == '0)
    else $error("outputs not zero while idle");
  chk_swi0_req: assert property (swi0_i && !(irq_ack_i && irq_req_o) |=> irq_req_o)
    else $error("request missing after source");
endmodule

// ===== vpit_core_model.sv
// Purpose: Core side that takes interrupt vectors
// Assumes: Request and vector stand until acknowledged
// Notes:   Acknowledge delay set by the bench
`timescale 1ns/1ps

module vpit_core_model (
  // Clock, reset, control
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   en_i,
  input  wire logic [3:0]             dly_i,
  // Request side
  input  wire logic                   irq_req_i,
  input  wire vpit_pkg::vpit_vector_t irq_vector_i,
  input  wire logic [20:0]            irq_fetch_addr_i,
  output logic                        irq_ack_o,
  // Observed fetches
  output vpit_pkg::vpit_vector_t      taken_vec_o,
  output logic [20:0]                 taken_addr_o,
  output logic [7:0]                  taken_cnt_o
);
  logic [3:0] wait_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_ack_o <= 1'b0;
      wait_q <= 4'h0;
      taken_vec_o <= '0;
      taken_addr_o <= '0;
      taken_cnt_o <= 8'h00;
    end else if (!en_i || irq_ack_o) begin
      irq_ack_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (irq_req_i && wait_q == dly_i) begin
      irq_ack_o <= 1'b1;
      taken_vec_o <= irq_vector_i;
      taken_addr_o <= irq_fetch_addr_i;
      taken_cnt_o <= taken_cnt_o + 8'h01;
    end else if (irq_req_i) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ===== vpit_top_test.sv
// Purpose: Self-checking bench for the interrupt table
// Assumes: Sources indexed by vector number
// Notes:   Inputs change on falling edges
`timescale 1ns/1ps
`include "vpit_map.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module vpit_top_test;
  import vpit_pkg::*;
  logic         sys_clk_i = 1'b0;
  logic         srst_i    = 1'b1;
  logic [49:0]  req_v     = '0;
  logic [99:0]  cfg       = '0;
  logic [15:0]  base      = 16'h0000;
  logic         core_en   = 1'b0;
  logic [3:0]   core_dly  = 4'h0;
  logic         irq_ack, irq_req;
  vpit_vector_t irq_vec, taken_vec;
  vpit_level_t  irq_lvl;
  logic [20:0]  irq_addr, taken_addr;
  logic [7:0]   taken_cnt;
  int           error_cnt = 0;
  int           tests_run = 0;
  int           cyc       = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  vpit_top dut_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .illegal_instr_i(req_v[2]), .swi3_i(req_v[3]), .stack_overflow_i(req_v[4]),
    .misaligned_i(req_v[5]), .swi2_i(req_v[14]), .swi1_i(req_v[15]), .swi0_i(req_v[16]),
    .debug_port_step_i(req_v[6]), .debug_port_brk0_i(req_v[7]),
    .debug_port_trace_i(req_v[9]), .debug_port_tx_empty_i(req_v[10]),
    .debug_port_rx_full_i(req_v[11]), .external_irq_pin_a_i(req_v[17]),
    .external_irq_pin_b_i(req_v[18]), .low_voltage_detect_i(req_v[20]),
    .clock_synth_i(req_v[21]), .flash_controller_err_i(req_v[22]),
    .flash_controller_done_i(req_v[23]), .flash_controller_empty_i(req_v[24]),
    .can_irq_i(req_v[29:26]),
    .gpio_port_event_i({req_v[30], req_v[31], req_v[32], req_v[33], req_v[34], req_v[35]}),
    .sync_serial_1_i(req_v[39:38]), .sync_serial_0_i(req_v[41:40]),
    .async_serial_1_tx_empty_i(req_v[42]), .async_serial_1_tx_idle_i(req_v[43]),
    .async_serial_1_rx_error_i(req_v[45]), .async_serial_1_rx_full_i(req_v[46]),
    .quad_decoder_1_home_i(req_v[47]), .quad_decoder_1_index_i(req_v[48]),
    .quad_decoder_0_home_i(req_v[49]), .vector_table_base_i(base), .level_cfg_i(cfg),
    .irq_ack_i(irq_ack), .irq_req_o(irq_req), .irq_vector_o(irq_vec),
    .irq_level_o(irq_lvl), .irq_fetch_addr_o(irq_addr)
  );

  vpit_core_model core_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .en_i(core_en), .dly_i(core_dly),
    .irq_req_i(irq_req), .irq_vector_i(irq_vec), .irq_fetch_addr_i(irq_addr),
    .irq_ack_o(irq_ack), .taken_vec_o(taken_vec), .taken_addr_o(taken_addr),
    .taken_cnt_o(taken_cnt)
  );

  function automatic logic [49:0] bv(int v);
    return 50'h1 << v;
  endfunction

  function automatic logic [1:0] exp_lvl(int v);
    logic [1:0] c;
    c = cfg[2*v +: 2];
    if (v <= 5) return 2'h3;
    if (v >= 14 && v <= 16) return 2'(16 - v);
    if (v <= 11) return (c == 2'h0) ? 2'h1 : c;
    return (c == 2'h3) ? 2'h2 : c;
  endfunction

  function automatic logic [20:0] exp_addr(int v);
    return 21'({base, 8'h00}) + 21'(2 * v);
  endfunction

  task automatic settle(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_each();
    for (int v = 0; v < 50; v++) begin
      @(negedge sys_clk_i);
      cfg[2*v +: 2] = 2'((v + 2) % 4);
      req_v = bv(v);
      settle(1);
      if (v inside {0, 1, 8, 12, 13, 19, 25, 36, 37, 44}) begin
        `CHK(irq_req, 1'b0)
      end else begin
        `CHK(irq_vec, 6'(v))
        `CHK(irq_lvl, exp_lvl(v))
        `CHK(irq_addr, exp_addr(v))
      end
    end
    $display("t_each done");
  endtask

  task automatic win(logic [49:0] m, int v);
    @(negedge sys_clk_i);
    req_v = m;
    settle(1);
    `CHK(irq_vec, 6'(v))
  endtask

  task automatic t_order();
    cfg = '0;
    cfg[98 +: 2] = 2'h2;
    cfg[60 +: 2] = 2'h1;
    cfg[12 +: 2] = 2'h1;
    win(bv(16) | bv(49), 49);
    win(bv(30) | bv(49), 49);
    cfg[60 +: 2] = 2'h2;
    win(bv(30) | bv(49), 30);
    win(bv(6) | bv(30), 30);
    cfg[12 +: 2] = 2'h3;
    win(bv(6) | bv(30), 6);
    win(bv(2) | bv(6), 2);
    win(bv(15) | bv(16), 15);
    win(bv(3) | bv(4) | bv(5), 3);
    $display("t_order done");
  endtask

  task automatic t_base();
    @(negedge sys_clk_i);
    req_v = bv(49);
    base = 16'h0fff;
    settle(3);
    `CHK(irq_addr, 21'h0fff62)
    base = 16'h0200;
    settle(1);
    `CHK(irq_addr, 21'h0fff62)
    settle(1);
    `CHK(irq_addr, 21'h020062)
    $display("t_base done");
  endtask

  task automatic t_ack();
    logic [7:0] n0;
    for (int d = 0; d < 4; d += 3) begin
      @(negedge sys_clk_i);
      n0 = taken_cnt;
      req_v = bv(22);
      core_dly = 4'(d);
      core_en = 1'b1;
      settle(2 * d + 8);
      core_en = 1'b0;
      `CHK(taken_vec, 6'd22)
      `CHK(taken_addr, exp_addr(22))
      `CHK(8'(taken_cnt - n0) > 8'd1, 1'b1)
    end
    req_v = '0;
    $display("t_ack done");
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    settle(10);
    srst_i = 1'b0;
    settle(2);
    `CHK(irq_req, 1'b0)
    t_each();
    t_order();
    t_base();
    t_ack();
    test_done();
  end
endmodule

bind vpit_top vpit_top_asserts #(.NUM_VEC(NUM_VEC)) chk_u (.*);
